/* core/udma_pkg.sv */
// Shared constants and carrier types for the USB pipe DMA channel engine.
// Assumes one clock domain and a 32-bit system bus master with word-aligned byte addresses.
package udma_pkg;
   localparam logic [7:0]  OFS_NEXT = 8'h00;
   localparam logic [7:0]  OFS_ADDR = 8'h04;
   localparam logic [7:0]  OFS_CTRL = 8'h08;
   localparam logic [7:0]  OFS_STAT = 8'h0c;
   localparam logic [7:0]  OFS_PCTL = 8'h10;
   localparam logic [7:0]  OFS_PFLG = 8'h14;
   localparam logic [7:0]  OFS_GLB  = 8'h18;
   // Control word fields
   localparam int C_EN      = 0;
   localparam int C_LDNXT   = 1;
   localparam int C_SPCLOSE = 2;
   localparam int C_RELEN   = 3;
   localparam int C_IE_EOT  = 4;
   localparam int C_IE_EOB  = 5;
   localparam int C_IE_DLD  = 6;
   localparam int C_LEN_LSB = 16;
   // Status word fields
   localparam int S_EN      = 0;
   localparam int S_ACT     = 1;
   localparam int S_EOT     = 4;
   localparam int S_EOB     = 5;
   localparam int S_DLD     = 6;
   localparam int S_LEN_LSB = 16;
   // Pipe flag positions and widths
   localparam int PF_RXIN = 0;
   localparam int PF_CRC  = 10;
   localparam int PF_N    = 11;
   localparam int HF_N    = 7;
   // Descriptor words sit at offsets 0, 4 and 8
   localparam logic [31:0] DESC_STEP       = 32'h4;
   localparam logic [1:0]  DESC_WORDS_LAST = 2'h2;
   // Burst limits
   localparam logic [8:0]  BURST_MAX      = 9'h100;
   localparam logic [8:0]  LOCK_BULK      = 9'h080;
   localparam logic [8:0]  LOCK_ISO       = 9'h100;
   localparam logic [10:0] BOUNDARY_BYTES = 11'h400;
   localparam logic [15:0] WORD_BYTES     = 16'h4;
   // Lag count loaded as control enable drops; status enable drops 3 cycles after it
   localparam logic [1:0]  STAT_LAG       = 2'h2;
   localparam logic [31:0] RST_WORD       = 32'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_LAG, ST_FETCH} udma_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } udma_reg_req_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        last;
      logic [31:0] addr;
      logic [31:0] wdata;
   } udma_mem_req_t;
endpackage

/* core/udma_engine.sv */
// One DMA channel of a USB pipe controller with pipe and host flag logic.
// Assumes endpoint FIFO and bus fabric on ref_clk_i; grant marks a beat.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module udma_engine
(
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   input  wire udma_pkg::udma_reg_req_t reg_i,
   output logic [31:0]                 reg_rdata_o,
   output udma_pkg::udma_mem_req_t     mem_o,
   input  wire logic                   mem_gnt_i,
   input  wire logic [31:0]            mem_rdata_i,
   input  wire logic                   ep_is_in_i,
   input  wire logic                   ep_is_iso_i,
   input  wire logic [10:0]            ep_size_i,
   input  wire logic                   ep_rd_valid_i,
   input  wire logic [31:0]            ep_rd_data_i,
   input  wire logic                   ep_rd_last_i,
   input  wire logic                   ep_rd_short_i,
   output logic                        ep_rd_o,
   input  wire logic                   ep_wr_ready_i,
   output logic                        ep_wr_o,
   output logic [31:0]                 ep_wr_data_o,
   output logic                        ep_bank_release_o,
   input  wire logic                   pipe_iso_in_i,
   input  wire logic [10:0]            pipe_evt_i,
   input  wire logic [6:0]             host_evt_i,
   output logic                        pipe_summary_irq_o,
   output logic                        dma_channel_summary_irq_o
);

   function automatic logic [8:0] min9(input logic [8:0] a,
                                       input logic [8:0] b);
      min9 = (a < b) ? a : b;
   endfunction

   udma_pkg::udma_state_t   state_r;
   udma_pkg::udma_state_t   state_nxt;
   udma_pkg::udma_mem_req_t mem_r;
   udma_pkg::udma_mem_req_t mem_nxt;
   logic [31:0] next_r;
   logic [31:0] next_nxt;
   logic [31:0] addr_r;
   logic [31:0] addr_nxt;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic [15:0] rem_r;
   logic [15:0] rem_nxt;
   logic [31:0] fnext_r;
   logic [31:0] fnext_nxt;
   logic [31:0] faddr_r;
   logic [31:0] faddr_nxt;
   logic [8:0]  beat_r;
   logic [8:0]  beat_nxt;
   logic [1:0]  lag_r;
   logic [1:0]  lag_nxt;
   logic [1:0]  fidx_r;
   logic [1:0]  fidx_nxt;
   logic        en_r;
   logic        en_nxt;
   logic        act_r;
   logic        act_nxt;
   logic        eot_r;
   logic        eot_nxt;
   logic        eob_r;
   logic        eob_nxt;
   logic        dld_r;
   logic        dld_nxt;
   logic        plast_r;
   logic        plast_nxt;
   logic        pshort_r;
   logic        pshort_nxt;
   logic        ep_rd_nxt;
   logic        ep_wr_nxt;
   logic [31:0] ep_wdat_nxt;
   logic        rel_nxt;
   logic [10:0] pflag_r;
   logic [10:0] pctl_r;
   logic [6:0]  hflag_r;
   logic [31:0] stat_w;

   // Register decode
   wire idle_w  = (state_r == udma_pkg::ST_IDLE);
   wire wr_next = reg_i.wr && (reg_i.addr == udma_pkg::OFS_NEXT);
   wire wr_addr = reg_i.wr && (reg_i.addr == udma_pkg::OFS_ADDR);
   wire wr_ctrl = reg_i.wr && (reg_i.addr == udma_pkg::OFS_CTRL);
   wire wr_stat = reg_i.wr && (reg_i.addr == udma_pkg::OFS_STAT);
   wire wr_pctl = reg_i.wr && (reg_i.addr == udma_pkg::OFS_PCTL);
   wire wr_pflg = reg_i.wr && (reg_i.addr == udma_pkg::OFS_PFLG);
   wire wr_glb  = reg_i.wr && (reg_i.addr == udma_pkg::OFS_GLB);

   // Direction follows endpoint type
   wire ep_out    = !ep_is_in_i;
   wire ep_ready  = ep_is_in_i ? ep_wr_ready_i : ep_rd_valid_i;
   wire beat_done = mem_r.req && mem_gnt_i;
   wire bus_quiet = !mem_r.req && !ep_rd_o && !ep_wr_o;

   // Burst length limits
   wire [8:0] lock_lim = ep_is_iso_i ? udma_pkg::LOCK_ISO
                                     : udma_pkg::LOCK_BULK;
   wire [8:0] psz_w    = ep_size_i[10:2];
   wire [8:0] lockcap  = min9(min9(lock_lim, psz_w),
                              udma_pkg::BURST_MAX);
   wire [10:0] nxt_off = {1'b0, addr_r[9:0]}
                         + udma_pkg::WORD_BYTES[10:0];
   wire at_bnd   = (nxt_off == udma_pkg::BOUNDARY_BYTES);
   wire len_last = (rem_r <= udma_pkg::WORD_BYTES);
   wire last_beat = (beat_r + 9'h1 >= lockcap) || len_last || at_bnd
                    || (ep_out && ep_rd_last_i);
   wire [15:0] rem_dec = len_last ? 16'h0
                                  : rem_r - udma_pkg::WORD_BYTES;
   wire [31:0] fetch_addr = next_r
                            + udma_pkg::DESC_STEP * 32'(fidx_r);

   // Pipe and host flags
   wire [10:0] pset = pipe_evt_i
                      & ~(11'(!pipe_iso_in_i) << udma_pkg::PF_CRC)
                      | (11'(pipe_evt_i[udma_pkg::PF_CRC]
                        && pipe_iso_in_i) << udma_pkg::PF_RXIN);
   wire [10:0] pclr = wr_pflg ? reg_i.wdata[10:0] : 11'h0;
   wire [6:0]  hclr = wr_glb ? reg_i.wdata[6:0] : 7'h0;
   wire pipe_sum = |(pflag_r & pctl_r);
   wire dma_sum  = (eot_r && ctrl_r[udma_pkg::C_IE_EOT])
                   || (eob_r && ctrl_r[udma_pkg::C_IE_EOB])
                   || (dld_r && ctrl_r[udma_pkg::C_IE_DLD]);

   always_comb
   begin
      stat_w = udma_pkg::RST_WORD;
      stat_w[udma_pkg::S_EN] = en_r;
      stat_w[udma_pkg::S_ACT] = act_r;
      stat_w[udma_pkg::S_EOT] = eot_r;
      stat_w[udma_pkg::S_EOB] = eob_r;
      stat_w[udma_pkg::S_DLD] = dld_r;
      stat_w[udma_pkg::S_LEN_LSB +: 16] = rem_r;
   end

   wire [31:0] glb_w = {23'h0, dma_sum, pipe_sum, hflag_r};
   wire [31:0] rd_word =
      (reg_i.addr == udma_pkg::OFS_NEXT) ? next_r :
      (reg_i.addr == udma_pkg::OFS_ADDR) ? addr_r :
      (reg_i.addr == udma_pkg::OFS_CTRL) ? ctrl_r :
      (reg_i.addr == udma_pkg::OFS_STAT) ? stat_w :
      (reg_i.addr == udma_pkg::OFS_PCTL) ? {21'h0, pctl_r} :
      (reg_i.addr == udma_pkg::OFS_PFLG) ? {21'h0, pflag_r} :
      (reg_i.addr == udma_pkg::OFS_GLB)  ? glb_w :
      udma_pkg::RST_WORD;

   always_comb
   begin
      state_nxt   = state_r;
      mem_nxt     = mem_r;
      next_nxt    = next_r;
      addr_nxt    = addr_r;
      ctrl_nxt    = ctrl_r;
      rem_nxt     = rem_r;
      fnext_nxt   = fnext_r;
      faddr_nxt   = faddr_r;
      beat_nxt    = beat_r;
      lag_nxt     = lag_r;
      fidx_nxt    = fidx_r;
      en_nxt      = en_r;
      act_nxt     = act_r;
      eot_nxt     = eot_r;
      eob_nxt     = eob_r;
      dld_nxt     = dld_r;
      plast_nxt   = plast_r;
      pshort_nxt  = pshort_r;
      ep_rd_nxt   = 1'b0;
      ep_wr_nxt   = 1'b0;
      ep_wdat_nxt = ep_wr_data_o;
      rel_nxt     = 1'b0;
      // Writes to channel setup are only taken while the channel is idle
      if (idle_w && wr_next)
      begin
         next_nxt = reg_i.wdata;
      end
      if (idle_w && wr_addr)
      begin
         addr_nxt = reg_i.wdata;
      end
      if (idle_w && wr_ctrl)
      begin
         ctrl_nxt = reg_i.wdata;
         rem_nxt  = reg_i.wdata[udma_pkg::C_LEN_LSB +: 16];
         en_nxt   = reg_i.wdata[udma_pkg::C_EN];
      end
      // Status flags clear on write-one; a same-cycle set below wins
      if (wr_stat)
      begin
         eot_nxt = eot_r & ~reg_i.wdata[udma_pkg::S_EOT];
         eob_nxt = eob_r & ~reg_i.wdata[udma_pkg::S_EOB];
         dld_nxt = dld_r & ~reg_i.wdata[udma_pkg::S_DLD];
      end
      if (beat_done)
      begin
         mem_nxt.req = 1'b0;
      end
      case (state_r)
         udma_pkg::ST_IDLE:
         begin
            if (ctrl_r[udma_pkg::C_EN] && ep_ready)
            begin
               state_nxt  = udma_pkg::ST_XFER;
               act_nxt    = 1'b1;
               beat_nxt   = 9'h0;
               plast_nxt  = 1'b0;
               pshort_nxt = 1'b0;
            end
            else if (ctrl_r[udma_pkg::C_LDNXT] && ep_ready)
            begin
               state_nxt = udma_pkg::ST_FETCH;
               act_nxt   = 1'b1;
               fidx_nxt  = 2'h0;
            end
         end
         udma_pkg::ST_XFER:
         begin
            if (beat_done)
            begin
               addr_nxt = addr_r + udma_pkg::DESC_STEP;
               rem_nxt  = rem_dec;
               beat_nxt = mem_r.last ? 9'h0 : beat_r + 9'h1;
               if (!mem_r.we)
               begin
                  ep_wr_nxt   = 1'b1;
                  ep_wdat_nxt = mem_rdata_i;
               end
            end
            else if (bus_quiet && rem_r != 16'h0 && ep_ready)
            begin
               mem_nxt.req   = 1'b1;
               mem_nxt.we    = ep_out;
               mem_nxt.addr  = addr_r;
               mem_nxt.wdata = ep_rd_data_i;
               mem_nxt.last  = last_beat;
               if (ep_out)
               begin
                  ep_rd_nxt  = 1'b1;
                  plast_nxt  = ep_rd_last_i;
                  pshort_nxt = ep_rd_short_i;
               end
            end
            else if (bus_quiet && rem_r == 16'h0)
            begin
               ctrl_nxt[udma_pkg::C_EN] = 1'b0;
               eob_nxt   = 1'b1;
               rel_nxt   = ctrl_r[udma_pkg::C_RELEN] && ep_out;
               act_nxt   = 1'b0;
               lag_nxt   = udma_pkg::STAT_LAG;
               state_nxt = udma_pkg::ST_LAG;
            end
            else if (bus_quiet && ep_out && plast_r && pshort_r
                     && ctrl_r[udma_pkg::C_SPCLOSE])
            begin
               ctrl_nxt[udma_pkg::C_EN] = 1'b0;
               eot_nxt   = 1'b1;
               act_nxt   = 1'b0;
               plast_nxt = 1'b0;
               lag_nxt   = udma_pkg::STAT_LAG;
               state_nxt = udma_pkg::ST_LAG;
            end
            else if (bus_quiet && !ep_ready)
            begin
               act_nxt   = 1'b0;
               state_nxt = udma_pkg::ST_IDLE;
            end
         end
         udma_pkg::ST_LAG:
         begin
            if (lag_r == 2'h0)
            begin
               en_nxt = 1'b0;
               // Load-next is left set so the chain carries on
               state_nxt = ctrl_r[udma_pkg::C_LDNXT]
                           ? udma_pkg::ST_FETCH
                           : udma_pkg::ST_IDLE;
               fidx_nxt = 2'h0;
            end
            else
            begin
               lag_nxt = lag_r - 2'h1;
            end
         end
         udma_pkg::ST_FETCH:
         begin
            if (beat_done)
            begin
               fidx_nxt = fidx_r + 2'h1;
               if (fidx_r == 2'h0)
               begin
                  fnext_nxt = mem_rdata_i;
               end
               else if (fidx_r == 2'h1)
               begin
                  faddr_nxt = mem_rdata_i;
               end
               else
               begin
                  next_nxt  = fnext_r;
                  addr_nxt  = faddr_r;
                  ctrl_nxt  = mem_rdata_i;
                  rem_nxt   = mem_rdata_i[udma_pkg::C_LEN_LSB +: 16];
                  en_nxt    = mem_rdata_i[udma_pkg::C_EN];
                  dld_nxt   = 1'b1;
                  act_nxt   = 1'b0;
                  state_nxt = udma_pkg::ST_IDLE;
               end
            end
            else if (!mem_r.req)
            begin
               mem_nxt.req   = 1'b1;
               mem_nxt.we    = 1'b0;
               mem_nxt.addr  = fetch_addr;
               mem_nxt.wdata = udma_pkg::RST_WORD;
               mem_nxt.last  = (fidx_r == udma_pkg::DESC_WORDS_LAST);
            end
         end
         default:
         begin
            state_nxt = udma_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_r <= udma_pkg::ST_IDLE;
         mem_r   <= '0;
         next_r  <= udma_pkg::RST_WORD;
         addr_r  <= udma_pkg::RST_WORD;
         ctrl_r  <= udma_pkg::RST_WORD;
         rem_r   <= 16'h0;
         fnext_r <= udma_pkg::RST_WORD;
         faddr_r <= udma_pkg::RST_WORD;
         beat_r  <= 9'h0;
         lag_r   <= 2'h0;
         fidx_r  <= 2'h0;
         en_r    <= 1'b0;
         act_r   <= 1'b0;
         eot_r   <= 1'b0;
         eob_r   <= 1'b0;
         dld_r   <= 1'b0;
         plast_r <= 1'b0;
         pshort_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         mem_r   <= mem_nxt;
         next_r  <= next_nxt;
         addr_r  <= addr_nxt;
         ctrl_r  <= ctrl_nxt;
         rem_r   <= rem_nxt;
         fnext_r <= fnext_nxt;
         faddr_r <= faddr_nxt;
         beat_r  <= beat_nxt;
         lag_r   <= lag_nxt;
         fidx_r  <= fidx_nxt;
         en_r    <= en_nxt;
         act_r   <= act_nxt;
         eot_r   <= eot_nxt;
         eob_r   <= eob_nxt;
         dld_r   <= dld_nxt;
         plast_r <= plast_nxt;
         pshort_r <= pshort_nxt;
      end
   end

   // Port-side pulses and read data; outputs all come from flops
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         ep_rd_o           <= 1'b0;
         ep_wr_o           <= 1'b0;
         ep_wr_data_o      <= udma_pkg::RST_WORD;
         ep_bank_release_o <= 1'b0;
         reg_rdata_o       <= udma_pkg::RST_WORD;
      end
      else
      begin
         ep_rd_o           <= ep_rd_nxt;
         ep_wr_o           <= ep_wr_nxt;
         ep_wr_data_o      <= ep_wdat_nxt;
         ep_bank_release_o <= rel_nxt;
         reg_rdata_o       <= reg_i.rd ? rd_word : udma_pkg::RST_WORD;
      end
   end

   // Pipe and host flags: sticky, write-one clear, set wins
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         pflag_r <= 11'h0;
         pctl_r  <= 11'h0;
         hflag_r <= 7'h0;
         pipe_summary_irq_o        <= 1'b0;
         dma_channel_summary_irq_o <= 1'b0;
      end
      else
      begin
         pflag_r <= (pflag_r & ~pclr) | pset;
         pctl_r  <= wr_pctl ? reg_i.wdata[10:0] : pctl_r;
         hflag_r <= (hflag_r & ~hclr) | host_evt_i;
         pipe_summary_irq_o        <= pipe_sum;
         dma_channel_summary_irq_o <= dma_sum;
      end
   end

   assign mem_o = mem_r;

endmodule

/* tb/udma_engine_sva.sv */
// Port checker for the pipe DMA channel engine.
// Assumes one clock domain; bound onto udma_engine after the module.
`timescale 1ns/1ps
module udma_engine_sva (
   input wire logic                    ref_clk_i,
   input wire logic                    rst_i,
   input wire udma_pkg::udma_mem_req_t mem_o,
   input wire logic                    mem_gnt_i,
   input wire logic                    ep_is_in_i,
   input wire logic                    ep_is_iso_i,
   input wire logic [10:0]             ep_size_i,
   input wire logic                    ep_rd_o,
   input wire logic                    ep_wr_o,
   input wire logic                    ep_bank_release_o
);
   logic [8:0]  beats_r;
   logic [31:0] prev_r;
   wire         beat = mem_o.req && mem_gnt_i;
   wire [8:0]   lock = ep_is_iso_i ? udma_pkg::LOCK_ISO : udma_pkg::LOCK_BULK;
   wire [8:0]   cap  = lock < ep_size_i[10:2] ? lock : ep_size_i[10:2];
   // Beats already taken in the open burst; zero means no burst open
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || (beat && mem_o.last))
         beats_r <= 9'h0;
      else if (beat)
         beats_r <= beats_r + 9'h1;
      if (beat)
         prev_r <= mem_o.addr;
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_stall;
      mem_o.req && !mem_gnt_i;
   endsequence
   sequence s_held;
      mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wdata)
         && $stable(mem_o.we);
   endsequence
   req_hold_a: assert property (s_stall |=> s_held)
      else $error("beat changed before its grant");
   beat_gap_a: assert property (beat |=> !mem_o.req)
      else $error("request not dropped after grant");
   word_align_a: assert property (mem_o.req |-> mem_o.addr[1:0] == 2'h0)
      else $error("beat address not word aligned");
   kb_break_a: assert property (mem_o.req && mem_o.addr[9:2] == 8'hff
      |-> mem_o.last)
      else $error("burst crosses a 1 KB boundary");
   burst_cap_a: assert property (mem_o.req |-> beats_r < cap)
      else $error("burst longer than its cap");
   burst_incr_a: assert property (mem_o.req && beats_r != 9'h0
      |-> mem_o.addr == prev_r + 32'h4)
      else $error("burst address not ascending by one word");
   dir_write_a: assert property (mem_o.req && mem_o.we |-> !ep_is_in_i)
      else $error("memory write on an IN endpoint");
   push_dir_a: assert property (ep_wr_o |-> $past(ep_is_in_i))
      else $error("endpoint push on an OUT endpoint");
   pop_pulse_a: assert property (ep_rd_o |-> !ep_is_in_i ##1 !ep_rd_o)
      else $error("endpoint pop wrong direction or too long");
   release_a: assert property (ep_bank_release_o
      |-> !ep_is_in_i ##1 !ep_bank_release_o)
      else $error("bank release wrong direction or too long");
endmodule
bind udma_engine udma_engine_sva u_sva (
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .mem_o(mem_o),
   .mem_gnt_i(mem_gnt_i),
   .ep_is_in_i(ep_is_in_i),
   .ep_is_iso_i(ep_is_iso_i),
   .ep_size_i(ep_size_i),
   .ep_rd_o(ep_rd_o),
   .ep_wr_o(ep_wr_o),
   .ep_bank_release_o(ep_bank_release_o)
);

/* tb/udma_mem_model.sv */
// System memory partner: word store with prompt or slow grant.
// Assumes word-aligned byte addresses; only a 16-word window, aliased.
`timescale 1ns/1ps
module udma_mem_model (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_i,
   input  wire udma_pkg::udma_mem_req_t mem_i,
   input  wire logic                    slow_i,
   output logic                         gnt_o,
   output logic [31:0]                  rdata_o
);
   logic [31:0] mem [16];
   logic [31:0] last_r = '0;
   logic [1:0]  wait_r;
   // Slow mode withholds grant, as lost arbitration would
   assign gnt_o = mem_i.req && (!slow_i || wait_r == 2'h3);
   // Outside a grant the bus shows the inverse of its last granted word
   assign rdata_o = gnt_o ? mem[mem_i.addr[5:2]] : ~last_r;
   always @(posedge ref_clk_i)
   begin
      if (rst_i || gnt_o || !mem_i.req)
         wait_r <= 2'h0;
      else
         wait_r <= wait_r + 2'h1;
      if (gnt_o && mem_i.we)
         mem[mem_i.addr[5:2]] <= mem_i.wdata;
      if (gnt_o)
         last_r <= rdata_o;
   end
endmodule

/* tb/test_usb_host_dma_descriptor_engine.sv */
// Self-checking bench for the pipe DMA channel engine.
// Assumes udma_mem_model as memory; the endpoint FIFO is modelled here.
`timescale 1ns/1ps
module test_usb_host_dma_descriptor_engine;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] w;
      logic [31:0] e;
   } udma_row_t;
   udma_row_t rows [6] = '{
      '{8'h00, 32'h1234_5670, 32'h1234_5670},
      '{8'h04, 32'h0000_0abc, 32'h0000_0abc},
      '{8'h0c, 32'h0000_0070, 32'h0000_0000},
      '{8'h08, 32'h0010_0070, 32'h0010_0070},
      '{8'h10, 32'hffff_ffff, 32'h0000_07ff},
      '{8'h40, 32'hffff_ffff, 32'h0000_0000}};
   logic                    ref_clk_i = 1'b0;
   logic                    rst_i     = 1'b1;
   udma_pkg::udma_reg_req_t rq        = '0;
   udma_pkg::udma_mem_req_t mem;
   logic [31:0]             rdata, mrd, epw, d;
   logic                    gnt, ep_rd, ep_wr, rel, psum, dsum;
   logic                    slow  = 1'b1;
   logic                    is_in = 1'b0;
   logic                    iso   = 1'b1;
   logic                    ep_sh = 1'b0;
   logic [10:0]             pev   = '0;
   logic [6:0]              hev   = '0;
   logic [3:0]              ep_cnt = '0;
   logic [31:0]             inq [$];
   int                      n_mismatch = 0;
   int                      tests_run  = 0;
   int                      rel_n      = 0;
   int                      i;
   wire [31:0]              ep_word = {28'hd0da000, ep_cnt};
   always #20 ref_clk_i = ~ref_clk_i;
   // Endpoint FIFO: a drained FIFO shows the inverted word, not the last
   always @(posedge ref_clk_i)
   begin
      if (ep_rd)
         ep_cnt <= ep_cnt - 4'h1;
      if (ep_wr)
         inq.push_back(epw);
      if (rel)
         rel_n++;
   end
   udma_engine u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_i(rq),
      .reg_rdata_o(rdata), .mem_o(mem), .mem_gnt_i(gnt), .mem_rdata_i(mrd),
      .ep_is_in_i(is_in), .ep_is_iso_i(1'b0), .ep_size_i(11'h040),
      .ep_rd_valid_i(ep_cnt != 4'h0),
      .ep_rd_data_i(ep_cnt != 4'h0 ? ep_word : ~ep_word),
      .ep_rd_last_i(ep_cnt == 4'h1), .ep_rd_short_i(ep_sh), .ep_rd_o(ep_rd),
      .ep_wr_ready_i(1'b1), .ep_wr_o(ep_wr), .ep_wr_data_o(epw),
      .ep_bank_release_o(rel), .pipe_iso_in_i(iso), .pipe_evt_i(pev),
      .host_evt_i(hev), .pipe_summary_irq_o(psum),
      .dma_channel_summary_irq_o(dsum));
   udma_mem_model u_mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_i(mem),
      .slow_i(slow), .gnt_o(gnt), .rdata_o(mrd));
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk32(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task chk1(input string n, input logic e, input logic g);
      chk32(n, {31'h0, e}, {31'h0, g});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      rq <= '{1'b1, 1'b0, a, v};
      @(posedge ref_clk_i);
      rq <= '0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      rq <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge ref_clk_i);
      rq <= '0;
      @(negedge ref_clk_i);
      v = rdata;
   endtask
   // Polls status; a bound that runs out ends the run
   task wait_st(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      int          k;
      v = ~e;
      for (k = 0; k < 100 && (v & m) !== e; k++)
         rd(8'h0c, v);
      chk32("status", e, v & m);
      if ((v & m) !== e)
         final_report();
   endtask
   task tdone(input string n);
      $display("test %s done", n);
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rows[k])
      begin
         rd(rows[k].a, d);
         chk32("reset value", 32'h0, d);
         wr(rows[k].a, rows[k].w);
         rd(rows[k].a, d);
         chk32("readback", rows[k].e, d);
      end
      tdone("registers");
      for (i = 0; i < 11; i++)
      begin
         @(posedge ref_clk_i);
         pev <= 11'h1 << i;
         hev <= i < 7 ? 7'h1 << i : 7'h0;
         @(posedge ref_clk_i);
         pev <= '0;
         hev <= '0;
         rd(8'h14, d);
         chk32("pipe flags", i == 10 ? 32'h401 : 32'h1 << i, d);
         chk1("pipe summary", 1'b1, psum);
         rd(8'h18, d);
         chk32("host flags", i < 7 ? 32'h1 << i : 32'h0, d & 32'h7f);
         chk1("pipe in global", 1'b1, d[7]);
         wr(8'h14, 32'h7ff);
         wr(8'h18, 32'h7f);
      end
      // CRC event on a pipe that is not isochronous IN is ignored
      @(posedge ref_clk_i);
      iso <= 1'b0;
      pev <= 11'h400;
      @(posedge ref_clk_i);
      pev <= '0;
      rd(8'h14, d);
      chk32("crc off iso", 32'h0, d);
      chk1("pipe summary", 1'b0, psum);
      tdone("flags");
      wr(8'h04, 32'h3f8);
      wr(8'h08, 32'h0010_0009);
      rd(8'h0c, d);
      chk32("armed", 32'h1, d & 32'h3);
      @(posedge ref_clk_i);
      ep_cnt <= 4'h4;
      wait_st(32'hffff_ffff, 32'h20);
      for (i = 0; i < 4; i++)
         chk32("out word", ep_word_exp(4 - i), u_mem.mem[(14 + i) % 16]);
      chk32("release count", 32'(rel_n), 32'h1);
      rd(8'h08, d);
      chk32("ctrl enable", 32'h0, d & 32'h1);
      wr(8'h0c, 32'h70);
      tdone("single block");
      wr(8'h04, 32'h08);
      @(posedge ref_clk_i);
      ep_sh <= 1'b1;
      ep_cnt <= 4'h2;
      wr(8'h08, 32'h0040_0015);
      wait_st(32'hffff_ffff, 32'h0038_0010);
      chk32("short word", ep_word_exp(2), u_mem.mem[2]);
      chk32("short word", ep_word_exp(1), u_mem.mem[3]);
      chk1("dma summary", 1'b1, dsum);
      wr(8'h0c, 32'h70);
      rd(8'h0c, d);
      chk1("dma summary", 1'b0, dsum);
      @(posedge ref_clk_i);
      ep_sh <= 1'b0;
      tdone("short close");
      u_mem.mem[6] = 32'hcafe_0001;
      u_mem.mem[7] = 32'hcafe_0002;
      slow <= 1'b0;
      is_in <= 1'b1;
      wr(8'h04, 32'h18);
      wr(8'h08, 32'h0008_0001);
      wait_st(32'hffff_ffff, 32'h20);
      chk32("in count", 32'h2, 32'(inq.size()));
      for (i = 0; i < inq.size(); i++)
         chk32("in word", 32'hcafe_0001 + 32'(i), inq[i]);
      @(posedge ref_clk_i);
      is_in <= 1'b0;
      wr(8'h0c, 32'h70);
      tdone("in block");
      u_mem.mem[8] = 32'h0;
      u_mem.mem[9] = 32'h30;
      u_mem.mem[10] = 32'h0004_0041;
      wr(8'h00, 32'h20);
      wr(8'h04, 32'h10);
      @(posedge ref_clk_i);
      ep_cnt <= 4'h1;
      wr(8'h08, 32'h0004_0043);
      wait_st(32'h40, 32'h40);
      rd(8'h04, d);
      chk32("loaded addr", 32'h30, d);
      rd(8'h00, d);
      chk32("loaded next", 32'h0, d);
      rd(8'h08, d);
      chk32("loaded ctrl", 32'h0004_0041, d);
      chk1("dma summary", 1'b1, dsum);
      wr(8'h0c, 32'h70);
      rd(8'h0c, d);
      chk32("reloaded", 32'h1, d & 32'h73);
      @(posedge ref_clk_i);
      ep_cnt <= 4'h1;
      wait_st(32'h21, 32'h20);
      chk32("block one", ep_word_exp(1), u_mem.mem[4]);
      chk32("block two", ep_word_exp(1), u_mem.mem[12]);
      rd(8'h08, d);
      chk32("chain end", 32'h0, d & 32'h3);
      tdone("linked chain");
      final_report();
   end
   function automatic logic [31:0] ep_word_exp(input int c);
      return {28'hd0da000, 4'(c)};
   endfunction
endmodule
